/* File: pkg/dsip_pkg.sv */
`default_nettype none
// =====================================================================
// Constants of the serial converter write port
package dsip_pkg;
    // Frame geometry
    localparam int unsigned FRAME_BITS    = 24;
    localparam int unsigned BIT_CNT_W     = 5;
    localparam logic [4:0]  LAST_BIT      = 5'h17;
    // Field positions within the 24-bit word
    localparam int unsigned CODE_MSB      = 19;
    localparam int unsigned CODE_LSB      = 2;
    localparam int unsigned CODE_W        = 18;
    localparam int unsigned BASE_MSB      = 19;
    localparam int unsigned BASE_LSB      = 4;
    localparam int unsigned BASE_W        = 16;
    localparam int unsigned INTERP_HI_POS = 3;
    localparam int unsigned INTERP_LO_POS = 2;
    // Reset values
    localparam logic [17:0] CODE_RESET    = 18'h00000;
    // Interpolator duty sequencer: four phases per period
    localparam int unsigned PHASE_W       = 2;
    // Word buffer between frame capture and code register
    localparam int unsigned FIFO_DEPTH    = 16;
    localparam int unsigned FIFO_AW       = 4;
endpackage : dsip_pkg
`default_nettype wire

/* File: src/dsip_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// Synchronous FIFO with valid/ready on both sides
module dsip_fifo #(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = 4
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             do_wr;
    logic             do_rd;

    // Full when pointers differ only in the wrap bit
    assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    // Storage, no reset needed on data
    always_ff @(posedge clock) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // dsip_fifo
`default_nettype wire

/* File: src/dsip_port.sv */
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// Serial write port of an 18-bit converter: frame capture, word buffer,
// code register and interpolator duty sequencer.
// Latency: a word reaches the code register 3 to 6 clocks after its last edge is seen, when the buffer is empty.
module dsip_port
    import dsip_pkg::*;
(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rst,
    // Serial link pins
    input  wire logic                sync_n,
    input  wire logic                sclk,
    input  wire logic                sdin,
    // Converter core drive
    output logic [CODE_W-1:0]        dac_code,
    output logic [BASE_W-1:0]        base_code_bits,
    output logic                     interp_code_hi,
    output logic                     interp_code_lo,
    output logic [BASE_W-1:0]        core_code,
    output logic                     code_update,
    // Status
    output logic                     frame_active,
    output logic                     frame_abort,
    output logic                     word_dropped
);
    // =================================================================
    // Pin synchronisers
    // Pin order within the vectors: 2 frame-select, 1 serial clock, 0 data
    localparam int unsigned PIN_N    = 3;
    localparam int unsigned PIN_SYNC = 2;
    localparam int unsigned PIN_SCLK = 1;
    localparam int unsigned PIN_SDIN = 0;
    // Chains start at the idle levels (frame-select and clock high), so
    // filling them after reset never looks like a pin edge
    localparam logic [2:0]  PIN_IDLE = 3'b110;

    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_meta;
    logic [PIN_N-1:0] pin_sync;
    logic             sclk_d;
    logic             sync_n_d;

    // Pins gathered so one loop builds every chain
    assign pin_raw = {sync_n, sclk, sdin};

    // Two stages on every pin; only the second stage is read by logic
    for (genvar g = 0; g < PIN_N; g++) begin : g_pin_sync
        always_ff @(posedge clock) begin
            if (rst) begin
                pin_meta[g] <= PIN_IDLE[g];
                pin_sync[g] <= PIN_IDLE[g];
            end else begin
                pin_meta[g] <= pin_raw[g];
                pin_sync[g] <= pin_meta[g];
            end
        end
    end

    // Edge history taken from the second stage only, reset to idle levels
    always_ff @(posedge clock) begin
        if (rst) begin
            sclk_d   <= PIN_IDLE[PIN_SCLK];
            sync_n_d <= PIN_IDLE[PIN_SYNC];
        end else begin
            sclk_d   <= pin_sync[PIN_SCLK];
            sync_n_d <= pin_sync[PIN_SYNC];
        end
    end

    logic sclk_fall;
    logic sync_rise;
    logic sync_low;
    logic sdin_bit;

    // The serial clock is sampled, not used as a clock: each of its levels
    // must last more than one system clock or a falling edge can be missed
    assign sclk_fall = sclk_d && !pin_sync[PIN_SCLK];
    assign sync_rise = !sync_n_d && pin_sync[PIN_SYNC];
    // Data travels the same two stages as the clock, so setup is kept
    assign sdin_bit  = pin_sync[PIN_SDIN];
    assign sync_low  = !pin_sync[PIN_SYNC];

    // =================================================================
    // Frame state machine
    // Idle waits for frame-select low, shift counts falling edges, done
    // holds off extra clocks until frame-select returns high
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE  = 3'b100
    } dsip_state_t;

    dsip_state_t              state;
    dsip_state_t              next_state;
    logic [FRAME_BITS-1:0]    shreg;
    logic [BIT_CNT_W-1:0]     bit_cnt;
    logic                     word_push;

    // Last edge of a word: the 24th fall, seen while the count reads 23.
    // Used by the state, the shifter and the abort so they never disagree
    function automatic logic last_edge(input logic                 fall,
                                       input logic [BIT_CNT_W-1:0] cnt);
        return fall && (cnt == LAST_BIT);
    endfunction

    // Done waits for frame-select high so extra clocks cannot start a new word
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (sync_low) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                // A 24th fall sampled together with the frame-select rise still counts
                if (last_edge(sclk_fall, bit_cnt)) begin
                    next_state = ST_DONE;
                end else if (!sync_low) begin
                    next_state = ST_IDLE;
                end
            end
            ST_DONE: begin
                if (!sync_low) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // =================================================================
    // Shift register and bit counter
    // The counter resets whenever no frame is shifting, so an abort leaves
    // nothing behind for the next frame
    always_ff @(posedge clock) begin
        if (rst) begin
            shreg   <= '0;
            bit_cnt <= '0;
        end else if (state != ST_SHIFT || (!sync_low && !last_edge(sclk_fall, bit_cnt))) begin
            // idle clocks do not load; a 24th fall that shares its
            // sample with the frame-select rise is still taken
            bit_cnt <= '0;
        end else if (sclk_fall) begin
            shreg   <= {shreg[FRAME_BITS-2:0], sdin_bit};
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // One push per completed frame, on the first cycle spent in done; the
    // done state then ignores further clocks until frame-select goes high
    logic done_first;
    always_ff @(posedge clock) begin
        if (rst) begin
            done_first <= 1'b0;
        end else begin
            done_first <= (state == ST_SHIFT) && (next_state == ST_DONE);
        end
    end

    assign word_push = (state == ST_DONE) && done_first;

    // Abort pulse when frame ends short
    always_ff @(posedge clock) begin
        if (rst) begin
            frame_abort <= 1'b0;
        end else begin
            frame_abort <= (state == ST_SHIFT) && sync_rise && !last_edge(sclk_fall, bit_cnt);
        end
    end

    // High from the cycle the frame opens until its word is complete
    always_ff @(posedge clock) begin
        if (rst) begin
            frame_active <= 1'b0;
        end else begin
            frame_active <= (next_state == ST_SHIFT);
        end
    end

    // =================================================================
    // Word buffer: code bits only, the rest are dropped here
    // Sixteen words let a host send frames back to back while the
    // sequencer waits for its period boundary
    logic [CODE_W-1:0] fifo_out;
    logic              fifo_valid;
    logic              fifo_in_ready;
    logic              fifo_pop;

    dsip_fifo #(
        .WIDTH (CODE_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (word_push),
        .in_ready  (fifo_in_ready),
        .in_data   (shreg[CODE_MSB:CODE_LSB]),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out)
    );

    // Overflow flag: a full buffer refuses the word, sticky until reset
    // A dropped word only shows here; the code register never sees it
    always_ff @(posedge clock) begin
        if (rst) begin
            word_dropped <= 1'b0;
        end else if (word_push && !fifo_in_ready) begin
            word_dropped <= 1'b1;
        end
    end

    // =================================================================
    // Code register and interpolator
    logic [PHASE_W-1:0] phase;

    // New code taken only at a period boundary, which stalls the buffer
    // so the duty pattern of the old code finishes cleanly
    assign fifo_pop = fifo_valid && (phase == 2'h3);

    // Code register: loads from the buffer and marks the load with a pulse
    always_ff @(posedge clock) begin
        if (rst) begin
            dac_code    <= CODE_RESET;
            code_update <= 1'b0;
        end else begin
            code_update <= fifo_pop;
            if (fifo_pop) begin
                dac_code <= fifo_out;
            end
        end
    end

    // Free-running four-phase counter; one period is four system clocks
    always_ff @(posedge clock) begin
        if (rst) begin
            phase <= '0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    // Field split of the live code
    // These are wires off the code register, so they change with it
    assign base_code_bits = dac_code[BASE_MSB-CODE_LSB:BASE_LSB-CODE_LSB];
    assign interp_code_hi = dac_code[INTERP_HI_POS-CODE_LSB];
    assign interp_code_lo = dac_code[INTERP_LO_POS-CODE_LSB];

    // Raised phase: phases below the interpolator code carry base+1, so a
    // code of n gives n raised phases out of every four
    function automatic logic raised_phase(input logic [PHASE_W-1:0] ph,
                                          input logic               hi,
                                          input logic               lo);
        return ph < {hi, lo};
    endfunction

    // base+1 for interp phases out of four. Limitation: at base
    // full scale the raised step cannot exist, so the top four codes all
    // give the same full-scale core code
    always_ff @(posedge clock) begin
        if (rst) begin
            core_code <= '0;
        end else if (raised_phase(phase, interp_code_hi, interp_code_lo)
                     && base_code_bits != 16'hffff) begin
            core_code <= base_code_bits + 16'h0001;
        end else begin
            core_code <= base_code_bits;
        end
    end
endmodule // dsip_port
`default_nettype wire

/* File: dv/dsip_port_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Checker on the converter port outputs
module dsip_port_monitor
    import dsip_pkg::*;
(
    // Clock and reset
    input wire logic              clock,
    input wire logic              rst,
    // Serial pins
    input wire logic              sync_n,
    input wire logic              sclk,
    input wire logic              sdin,
    // Core drive and status
    input wire logic [CODE_W-1:0] dac_code,
    input wire logic [BASE_W-1:0] base_code_bits,
    input wire logic              interp_code_hi,
    input wire logic              interp_code_lo,
    input wire logic [BASE_W-1:0] core_code,
    input wire logic              code_update,
    input wire logic              frame_active,
    input wire logic              frame_abort,
    input wire logic              word_dropped
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_base_map; base_code_bits == dac_code[17:2]; endproperty
    a_base_map: assert property (p_base_map)
        else $error("base code not taken from code bits");
    property p_interp_map; {interp_code_hi, interp_code_lo} == dac_code[1:0]; endproperty
    a_interp_map: assert property (p_interp_map)
        else $error("interpolator code not taken from code bits");
    // A code change is only legal around its update pulse
    property p_code_hold; $changed(dac_code) |-> code_update || $past(code_update); endproperty
    a_code_hold: assert property (p_code_hold)
        else $error("code changed without update");
    property p_upd_pulse; code_update |=> !code_update; endproperty
    a_upd_pulse: assert property (p_upd_pulse)
        else $error("update pulse too long");
    property p_idle_quiet; sync_n [*8] |-> !frame_active; endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("shifting while deselected");
    property p_core_span;
        core_code == $past(base_code_bits) || core_code == 16'($past(base_code_bits) + 1);
    endproperty
    a_core_span: assert property (p_core_span)
        else $error("core code outside base and base plus one");
    property p_interp_zero;
        dac_code == $past(dac_code, 2) && dac_code[1:0] == 2'h0 |-> core_code == base_code_bits;
    endproperty
    a_interp_zero: assert property (p_interp_zero)
        else $error("zero duty code alternates");
    // Quarter duty: one raised phase, then three at the base
    property p_duty_q;
        dac_code == $past(dac_code, 4) && dac_code[1:0] == 2'h1 && core_code != base_code_bits
            |=> (core_code == $past(base_code_bits)) [*3];
    endproperty
    a_duty_q: assert property (p_duty_q)
        else $error("quarter duty pattern wrong");
    property p_abort_pulse; frame_abort |=> !frame_abort; endproperty
    a_abort_pulse: assert property (p_abort_pulse)
        else $error("abort pulse too long");
endmodule // dsip_port_monitor
`default_nettype wire

/* File: dv/dsip_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Host writing frames; its clock idles high between frames
module dsip_host (
    // Bench clock, only used to place pin changes after its rising edge
    input  wire logic clock,
    // Serial pins
    output logic      sync_n,
    output logic      sclk,
    output logic      sdin
);
    initial begin
        sync_n = 1'b1;
        sclk   = 1'b1;
        sdin   = 1'b0;
    end
    // Send nbits at 160 ns per bit; framed low leaves the port deselected
    task automatic frame(input logic [23:0] w, input int nbits, input bit framed);
        @(posedge clock);
        #2 sync_n = ~framed;
        #40;
        for (int i = 0; i < nbits; i++) begin
            sdin = (i < 24) ? w[23-i] : ~sdin;
            #80 sclk = 1'b0;
            #80 sclk = 1'b1;
        end
        #40 sync_n = 1'b1;
        // Released line must not show the last bit
        sdin = ~sdin;
        #400;
    endtask
endmodule // dsip_host
`default_nettype wire

/* File: dv/dsip_port_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Bench for the converter write port
module dsip_port_tb;
    import dsip_pkg::*;
    logic              clock = 1'b0;
    logic              rst   = 1'b1;
    wire logic         sync_n, sclk, sdin;
    logic [CODE_W-1:0] dac_code, pend_code, last;
    logic [BASE_W-1:0] base_code_bits, core_code;
    logic              interp_code_hi, interp_code_lo, code_update;
    logic              frame_active, frame_abort, word_dropped;
    logic [CODE_W-1:0] q[$];
    logic [31:0]       seed = 32'h6b1b;
    bit                pend = 1'b0;
    int                error_cnt = 0;
    int                comparisons = 0;
    int                aborts = 0;

    always #10 clock = ~clock;

    dsip_host host (.clock(clock), .sync_n(sync_n), .sclk(sclk), .sdin(sdin));
    dsip_port DUT (.clock(clock), .rst(rst), .sync_n(sync_n), .sclk(sclk), .sdin(sdin),
        .dac_code(dac_code), .base_code_bits(base_code_bits), .interp_code_hi(interp_code_hi),
        .interp_code_lo(interp_code_lo), .core_code(core_code), .code_update(code_update),
        .frame_active(frame_active), .frame_abort(frame_abort), .word_dropped(word_dropped));

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Reference model: each update must deliver the next queued code
    always @(negedge clock) begin
        if (pend) check("dac_code", 24'(dac_code), 24'(pend_code));
        pend = 1'b0;
        if (frame_abort === 1'b1) aborts++;
        if (code_update === 1'b1 && q.size() == 0) check("extra_update", 24'h1, 24'h0);
        if (code_update === 1'b1 && q.size() > 0) begin
            pend_code = q.pop_front();
            pend = 1'b1;
        end
    end

    task automatic send(input logic [23:0] w, input int nbits, input bit framed);
        if (framed && nbits >= 24) begin
            q.push_back(w[19:2]);
            last = w[19:2];
        end
        dsip_port_tb.host.frame(w, nbits, framed);
    endtask
    // Wait for the model to empty, then count raised phases of the core
    task automatic drain(input int k);
        logic [15:0] base;
        int          hi;
        int          lo;
        for (int i = 0; i < 400 && (q.size() > 0 || pend); i++) @(posedge clock);
        if (q.size() > 0) begin
            error_cnt++;
            conclude();
        end
        base = last[17:2];
        hi = 0;
        lo = 0;
        repeat (12) @(negedge clock);
        repeat (8) begin
            @(negedge clock);
            if (core_code === base + 16'h1) hi++;
            else if (core_code === base) lo++;
        end
        if (base != 16'hffff) check("duty_hi", 24'(hi), 24'(2 * k));
        else check("duty_sat_lo", 24'(lo), 24'h8);
        if (base != 16'hffff) check("duty_lo", 24'(lo), 24'(8 - 2 * k));
        else check("duty_sat_hi", 24'(hi), 24'h0);
    endtask

    initial begin
        repeat (10) @(posedge clock);
        #2 rst = 1'b0;
        repeat (5) @(posedge clock);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            send({seed[23:4], 2'(k), seed[1:0]}, 24, 1'b1);
            drain(k);
        end
        // Zero and full scale, ignored bits set opposite
        send(24'hf00003, 24, 1'b1);
        drain(0);
        send(24'h0ffffc, 24, 1'b1);
        drain(3);
        // Short frames and deselected clocks leave the code alone
        send(24'h0aaaa8, 23, 1'b1);
        send(24'h055554, 10, 1'b1);
        send(24'h0fff00, 24, 1'b0);
        repeat (20) @(negedge clock);
        check("dac_held", 24'(dac_code), 24'(last));
        check("aborts", 24'(aborts), 24'h2);
        // Edges past the 24th are refused
        seed = lfsr(seed);
        send(seed[23:0], 26, 1'b1);
        drain(int'(seed[3:2]));
        check("word_dropped", 24'(word_dropped), 24'h0);
        conclude();
    end
endmodule // dsip_port_tb

bind dsip_port dsip_port_monitor u_mon (.clock(clock), .rst(rst), .sync_n(sync_n), .sclk(sclk),
    .sdin(sdin), .dac_code(dac_code), .base_code_bits(base_code_bits),
    .interp_code_hi(interp_code_hi), .interp_code_lo(interp_code_lo), .core_code(core_code),
    .code_update(code_update), .frame_active(frame_active), .frame_abort(frame_abort),
    .word_dropped(word_dropped));
`default_nettype wire
